// ### verilog/dbt_timer.sv
// Dual byte timer/counter with prescaler, match buffers, capture and APB slave
//
// How it works
// (R1) Eight-bit prescaler counts cycles, pulses when equal to its match register.
// (R2) Prescaler restarts at zero on its pulse or a write to its register.
// (R3) Prescaler stops while the hold input is high.
// (R4) Low byte counts only while control bit 6 is set.
// (R5) High byte counts only while control bit 7 is set.
// (R6) Control bit 4 picks prescaler pulses or external events for low byte.
// (R7) Control bit 5 picks prescaler pulses or low-byte carries for high byte.
// (R8) A byte clears when stopped or when it matches.
// (R9) Match when byte equals its buffer; sixteen-bit mode compares all bits.
// (R10) Low buffer follows its register when stopped, reloads on match when running.
// (R11) Mode 0: two independent prescaled eight-bit timers.
// (R12) Event modes advance once per external event; period is value plus one.
// (R13) Mode 3: sixteen-bit event counter with period value plus one.
// (R14) Mode 2: sixteen-bit prescaled timer, low carries into high.
// (R15) Eight-bit modes: low capture inputs copy low byte to low capture.
// (R16) Eight-bit modes: high capture inputs copy high byte to high capture.
// (R17) Sixteen-bit modes: high capture inputs copy both bytes at once.
// (R18) Interrupt request per byte when its flag and enable are both set.
// (R19) Count and capture bytes are read only.
// (R20) High buffer follows its register when stopped, reloads on match when running.
// (R21) Match flag sets while running and stays until software clears it.
// (R22) Sixteen-bit mode with both bytes running sets both flags in the same cycle.
// (R23) Sixteen-bit select joins bytes into one counter compared as a whole.
`timescale 1ns/1ps
`default_nettype none
module dbt_timer #(
    parameter int LO_CAP_N = 4,
    parameter int HI_CAP_N = 4
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clk_en,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [dbt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      hold_mode,
    input  wire logic                      external_count_input,
    input  wire logic [LO_CAP_N-1:0]       low_capture_input,
    input  wire logic [HI_CAP_N-1:0]       high_capture_input,
    output logic                           low_irq,
    output logic                           high_irq
);
    import dbt_pkg::*;

    if (LO_CAP_N < 1 || HI_CAP_N < 1) begin : g_cap_n_check
        $error("capture input counts must be at least one");
    end

    // Event inputs are detection levels from another domain; sync them first
    logic [1:0]          ext_sync_q;
    logic                ext_prev_q;
    logic [LO_CAP_N-1:0] lo_s1_q;
    logic [LO_CAP_N-1:0] lo_s2_q;
    logic [LO_CAP_N-1:0] lo_prev_q;
    logic [HI_CAP_N-1:0] hi_s1_q;
    logic [HI_CAP_N-1:0] hi_s2_q;
    logic [HI_CAP_N-1:0] hi_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync_q <= 2'h0;
            ext_prev_q <= 1'b0;
            lo_s1_q    <= '0;
            lo_s2_q    <= '0;
            lo_prev_q  <= '0;
            hi_s1_q    <= '0;
            hi_s2_q    <= '0;
            hi_prev_q  <= '0;
        end else if (clk_en) begin
            ext_sync_q <= {ext_sync_q[0], external_count_input};
            ext_prev_q <= ext_sync_q[1];
            lo_s1_q    <= low_capture_input;
            lo_s2_q    <= lo_s1_q;
            lo_prev_q  <= lo_s2_q;
            hi_s1_q    <= high_capture_input;
            hi_s2_q    <= hi_s1_q;
            hi_prev_q  <= hi_s2_q;
        end
    end

    // Each rising edge of a detection line counts as one event
    logic ext_event;
    logic lo_cap_event;
    logic hi_cap_event;
    assign ext_event    = ext_sync_q[1] & ~ext_prev_q;
    assign lo_cap_event = |(lo_s2_q & ~lo_prev_q);
    assign hi_cap_event = |(hi_s2_q & ~hi_prev_q);

    // Register state
    logic [7:0] control_q;
    logic [7:0] prescale_match_q;
    logic [7:0] prescale_cnt_q;
    logic [7:0] match_lo_q;
    logic [7:0] match_hi_q;
    logic [7:0] buf_lo_q;
    logic [7:0] buf_hi_q;
    logic [7:0] count_lo_q;
    logic [7:0] count_hi_q;
    logic [7:0] capt_lo_q;
    logic [7:0] capt_hi_q;

    logic low_run;
    logic high_run;
    logic sixteen;
    logic low_ext;
    assign low_run  = control_q[BIT_LOW_RUN];
    assign high_run = control_q[BIT_HIGH_RUN];
    assign sixteen  = control_q[BIT_SIXTEEN];
    assign low_ext  = control_q[BIT_LOW_EXT];

    // APB decode; every access completes in its first access cycle
    logic        wr_acc;
    logic        rd_acc;
    logic        mapped;
    logic [15:0] word_addr;
    assign word_addr = paddr[ADDR_W-1:2];
    assign mapped    = (paddr[1:0] == 2'b00) && (word_addr >= OFF_CONTROL) && (word_addr <= OFF_CAPT_HI);
    assign wr_acc    = psel & penable & pwrite & pready & clk_en;
    assign rd_acc    = psel & penable & ~pwrite & pready & clk_en;

    logic wr_control;
    logic wr_prescale;
    logic wr_match_lo;
    logic wr_match_hi;
    assign wr_control  = wr_acc && mapped && word_addr == OFF_CONTROL && pstrb[0];
    assign wr_prescale = wr_acc && mapped && word_addr == OFF_PRESCALE && pstrb[0];
    assign wr_match_lo = wr_acc && mapped && word_addr == OFF_MATCH_LO && pstrb[0];
    assign wr_match_hi = wr_acc && mapped && word_addr == OFF_MATCH_HI && pstrb[0];

    // Prescaler
    logic pre_pulse;
    assign pre_pulse = !hold_mode && (prescale_cnt_q == prescale_match_q); // R1 R3

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_cnt_q <= RST_COUNT;
        end else if (clk_en) begin
            if (wr_prescale || pre_pulse) begin
                prescale_cnt_q <= 8'h00; // R2
            end else if (!hold_mode) begin
                prescale_cnt_q <= prescale_cnt_q + 8'h01; // R1 R3
            end
        end
    end

    // Count clocks per mode
    logic lo_tick;
    logic hi_tick;
    logic lo_match;
    logic hi_match;
    logic lo_eq;
    logic hi_eq;
    logic lo_wrap;
    assign lo_tick = low_run & (low_ext ? ext_event : pre_pulse); // R4 R6 R11 R12
    assign lo_eq   = count_lo_q == buf_lo_q;
    assign hi_eq   = count_hi_q == buf_hi_q;
    // Sixteen-bit mode: low carries into high as it wraps past ff
    assign lo_wrap = count_lo_q == 8'hff;
    assign hi_tick = high_run & (sixteen ? (lo_tick & lo_wrap) : pre_pulse); // R5 R7 R14
    // A match is seen on the tick that would step past the buffer value
    assign lo_match = sixteen ? (lo_tick & lo_eq & hi_eq) : (lo_tick & lo_eq); // R9 R23 R13
    assign hi_match = sixteen ? lo_match : (hi_tick & hi_eq); // R9 R22

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_lo_q <= RST_COUNT;
        end else if (clk_en) begin
            if (!low_run || lo_match) begin
                count_lo_q <= 8'h00; // R8
            end else if (lo_tick) begin
                count_lo_q <= count_lo_q + 8'h01; // R12
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_hi_q <= RST_COUNT;
        end else if (clk_en) begin
            if (!high_run || hi_match) begin
                count_hi_q <= 8'h00; // R8
            end else if (hi_tick) begin
                count_hi_q <= count_hi_q + 8'h01; // R14
            end
        end
    end

    // Match buffers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_lo_q <= RST_MATCH;
            buf_hi_q <= RST_MATCH;
        end else if (clk_en) begin
            if (!low_run || lo_match) begin
                buf_lo_q <= match_lo_q; // R10
            end
            if (!high_run || hi_match) begin
                buf_hi_q <= match_hi_q; // R20
            end
        end
    end

    // Software registers; a match in the clearing cycle keeps its flag
    logic [7:0] control_d;
    always_comb begin
        control_d = control_q;
        if (wr_control) begin
            control_d = pwdata[7:0];
        end
        if (lo_match && low_run) begin
            control_d[BIT_LOW_FLAG] = 1'b1; // R21 R22
        end
        if (hi_match && high_run) begin
            control_d[BIT_HIGH_FLAG] = 1'b1; // R21 R22
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q        <= RST_CONTROL;
            prescale_match_q <= RST_PRESCALE;
            match_lo_q       <= RST_MATCH;
            match_hi_q       <= RST_MATCH;
        end else if (clk_en) begin
            control_q <= control_d;
            if (wr_prescale) begin
                prescale_match_q <= pwdata[7:0];
            end
            if (wr_match_lo) begin
                match_lo_q <= pwdata[7:0];
            end
            if (wr_match_hi) begin
                match_hi_q <= pwdata[7:0];
            end
        end
    end

    // Capture; undefined after reset in principle, zero here for determinism
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capt_lo_q <= RST_CAPT;
            capt_hi_q <= RST_CAPT;
        end else if (clk_en) begin
            if (sixteen) begin
                if (hi_cap_event) begin
                    capt_lo_q <= count_lo_q; // R17
                    capt_hi_q <= count_hi_q; // R17
                end
            end else begin
                if (lo_cap_event) begin
                    capt_lo_q <= count_lo_q; // R15
                end
                if (hi_cap_event) begin
                    capt_hi_q <= count_hi_q; // R16
                end
            end
        end
    end

    // Interrupt requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_irq  <= 1'b0;
            high_irq <= 1'b0;
        end else if (clk_en) begin
            low_irq  <= control_d[BIT_LOW_FLAG] & control_d[BIT_LOW_IE]; // R18
            high_irq <= control_d[BIT_HIGH_FLAG] & control_d[BIT_HIGH_IE]; // R18
        end
    end

    // Read mux; each byte sits in lane zero of its aligned word
    logic [7:0]  rd_byte;
    logic [31:0] rd_word;
    always_comb begin
        rd_byte = 8'h00;
        unique case (word_addr)
            OFF_CONTROL:  rd_byte = control_q;
            OFF_PRESCALE: rd_byte = prescale_match_q;
            OFF_COUNT_LO: rd_byte = count_lo_q; // R19
            OFF_COUNT_HI: rd_byte = count_hi_q; // R19
            OFF_MATCH_LO: rd_byte = match_lo_q;
            OFF_MATCH_HI: rd_byte = match_hi_q;
            OFF_CAPT_LO:  rd_byte = capt_lo_q; // R19
            OFF_CAPT_HI:  rd_byte = capt_hi_q; // R19
            default:      rd_byte = 8'h00;
        endcase
        rd_word = {24'h000000, rd_byte};
    end

    // Zero-wait slave: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    logic unused_ok;
    assign unused_ok = rd_acc | (|pwdata[31:8]) | (|pstrb[3:1]);

    a_pre_period: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && pre_pulse && !wr_prescale |=> prescale_cnt_q == 8'h00) // R2
        else $error("prescaler did not restart");
    a_pre_hold: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && hold_mode && !wr_prescale |=> prescale_cnt_q == $past(prescale_cnt_q)) // R3
        else $error("prescaler moved in hold");
    a_long_carry: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && sixteen && high_run && lo_tick && lo_wrap && !lo_match |=>
        count_hi_q == 8'($past(count_hi_q) + 8'h01)) // R14
        else $error("low byte did not carry");
    a_low_stop: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !low_run |=> count_lo_q == 8'h00) // R4
        else $error("stopped low byte not cleared");
    a_high_stop: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !high_run |=> count_hi_q == 8'h00) // R5
        else $error("stopped high byte not cleared");
    a_match_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && lo_match |=> count_lo_q == 8'h00) // R8
        else $error("low byte not cleared on match");
    a_buf_follow: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !low_run |=> buf_lo_q == $past(match_lo_q)) // R10
        else $error("low buffer not following");
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && hi_match && high_run |=> control_q[BIT_HIGH_FLAG]) // R21
        else $error("high flag not set");
    a_flags_joint: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && sixteen && low_run && high_run && lo_match |=>
        control_q[BIT_LOW_FLAG] && control_q[BIT_HIGH_FLAG]) // R22
        else $error("flags not set together");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        low_irq |-> $past(control_d[BIT_LOW_IE])) // R18
        else $error("low irq without enable");
endmodule
`default_nettype wire

// ### verilog/dbt_pkg.sv
// Register map and field positions of the dual byte timer/counter
package dbt_pkg;
    // Offsets are word indices; the byte address is four times the index
    localparam int          ADDR_W         = 18;
    localparam logic [15:0] OFF_CONTROL    = 16'hfe10;
    localparam logic [15:0] OFF_PRESCALE   = 16'hfe11;
    localparam logic [15:0] OFF_COUNT_LO   = 16'hfe12;
    localparam logic [15:0] OFF_COUNT_HI   = 16'hfe13;
    localparam logic [15:0] OFF_MATCH_LO   = 16'hfe14;
    localparam logic [15:0] OFF_MATCH_HI   = 16'hfe15;
    localparam logic [15:0] OFF_CAPT_LO    = 16'hfe16;
    localparam logic [15:0] OFF_CAPT_HI    = 16'hfe17;
    localparam logic [15:0] OFF_WORD_MASK  = 16'hfffc;
    localparam int          BIT_HIGH_RUN   = 7;
    localparam int          BIT_LOW_RUN    = 6;
    localparam int          BIT_SIXTEEN    = 5;
    localparam int          BIT_LOW_EXT    = 4;
    localparam int          BIT_HIGH_FLAG  = 3;
    localparam int          BIT_HIGH_IE    = 2;
    localparam int          BIT_LOW_FLAG   = 1;
    localparam int          BIT_LOW_IE     = 0;
    localparam logic [7:0]  RST_CONTROL    = 8'h00;
    localparam logic [7:0]  RST_PRESCALE   = 8'h00;
    localparam logic [7:0]  RST_COUNT      = 8'h00;
    localparam logic [7:0]  RST_MATCH      = 8'h00;
    localparam logic [7:0]  RST_CAPT       = 8'h00;
endpackage

// ### bench/dbt_timer_tb_top.sv
// Self-checking testbench of the dual byte timer/counter
`timescale 1ns/1ps
`default_nettype none
module dbt_timer_tb_top;
    import dbt_pkg::*;
    logic                pclk = 1'b0;
    logic                presetn = 1'b0;
    logic                clk_en = 1'b1;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [ADDR_W-1:0]   paddr = '0;
    logic [31:0]         pwdata = '0;
    logic [3:0]          pstrb = 4'hf;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                hold_mode = 1'b0;
    logic                ext_in = 1'b0;
    logic [3:0]          lo_cap = '0;
    logic [3:0]          hi_cap = '0;
    logic                low_irq;
    logic                high_irq;
    logic [32:0]         exp_q[$];
    logic [32:0]         e;
    int                  fails = 0;
    int                  samples_checked = 0;
    int                  seed = 32'h1415c444;
    int                  t_lo;
    int                  t_hi;
    logic [7:0]          v;

    dbt_timer u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .hold_mode(hold_mode), .external_count_input(ext_in),
        .low_capture_input(lo_cap), .high_capture_input(hi_cap), .low_irq(low_irq), .high_irq(high_irq));

    always #50 pclk = ~pclk;

    task automatic chk(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic results();
        if (exp_q.size() != 0) chk(1'b0, "reads left unanswered");
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready is seen high; byte address is four times the index
    task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            chk(1'b0, "no pready");
            results();
        end
        @(posedge pclk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        exp_q.push_back({1'b0, 24'h0, x});
        apb(1'b0, a, 8'h00);
    endtask

    // Rising edges on the count input, slow enough for the synchroniser
    task automatic ev(input int n);
        repeat (n) begin
            ext_in <= 1'b1;
            cyc(2);
            ext_in <= 1'b0;
            cyc(2);
        end
        cyc(2);
    endtask

    // Oldest note is compared whenever read data comes back
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (exp_q.size() == 0) chk(1'b0, "read with no note");
            else begin
                e = exp_q.pop_front();
                if (e[32]) chk(pslverr === 1'b1, "slave error missing");
                else chk({pslverr, prdata} === e, $sformatf("read %h want %h", prdata, e[7:0]));
            end
        end
    end

    initial begin
        cyc(3);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 8; i++) rd(OFF_CONTROL + 16'(i), 8'h00);
        exp_q.push_back({1'b1, 32'h0});
        apb(1'b0, 16'hfe18, 8'h00);
        wr(OFF_COUNT_LO, 8'hff);
        wr(OFF_CAPT_LO, 8'hff);
        rd(OFF_COUNT_LO, 8'h00);
        rd(OFF_CAPT_LO, 8'h00);
        pstrb <= 4'he;
        wr(OFF_MATCH_LO, 8'h5a);
        pstrb <= 4'hf;
        rd(OFF_MATCH_LO, 8'h00);
        for (int i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            wr((i == 0) ? OFF_PRESCALE : OFF_MATCH_LO + 16'(i - 1), v);
            rd((i == 0) ? OFF_PRESCALE : OFF_MATCH_LO + 16'(i - 1), v);
        end
        // Mode 1: event counter on the low byte
        wr(OFF_MATCH_LO, 8'h04);
        wr(OFF_CONTROL, 8'h51);
        ev(2);
        lo_cap <= 4'(1 << ($unsigned($random(seed)) % 4));
        cyc(2);
        lo_cap <= '0;
        cyc(4);
        wr(OFF_MATCH_LO, 8'h01);
        ev(2);
        rd(OFF_COUNT_LO, 8'h04);
        rd(OFF_CONTROL, 8'h51);
        chk(low_irq === 1'b0, "low irq early");
        ev(1);
        rd(OFF_COUNT_LO, 8'h00);
        rd(OFF_CONTROL, 8'h53);
        chk(low_irq === 1'b1, "low irq missing");
        rd(OFF_CAPT_LO, 8'h02);
        ev(2);
        rd(OFF_COUNT_LO, 8'h00);
        wr(OFF_CONTROL, 8'h51);
        rd(OFF_CONTROL, 8'h51);
        chk(low_irq === 1'b0, "low irq stuck");
        wr(OFF_CONTROL, 8'h50);
        wr(OFF_CONTROL, 8'h00);
        rd(OFF_COUNT_LO, 8'h00);
        // Mode 3: sixteen-bit event counter, carry and joint capture
        wr(OFF_MATCH_LO, 8'h30);
        wr(OFF_MATCH_HI, 8'h01);
        wr(OFF_CONTROL, 8'hf0);
        ev(300);
        rd(OFF_COUNT_LO, 8'h2c);
        rd(OFF_COUNT_HI, 8'h01);
        hi_cap <= 4'h8;
        cyc(2);
        hi_cap <= '0;
        cyc(4);
        rd(OFF_CAPT_LO, 8'h2c);
        rd(OFF_CAPT_HI, 8'h01);
        ev(4);
        rd(OFF_CONTROL, 8'hf0);
        ev(1);
        rd(OFF_CONTROL, 8'hfa);
        rd(OFF_COUNT_HI, 8'h00);
        wr(OFF_CONTROL, 8'h00);
        // Mode 0: prescaled timers, frozen by hold
        hold_mode <= 1'b1;
        wr(OFF_PRESCALE, 8'h03);
        wr(OFF_MATCH_LO, 8'h04);
        wr(OFF_MATCH_HI, 8'h01);
        wr(OFF_CONTROL, 8'hc5);
        cyc(30);
        rd(OFF_COUNT_LO, 8'h00);
        rd(OFF_CONTROL, 8'hc5);
        hold_mode <= 1'b0;
        t_lo = 0;
        t_hi = 0;
        for (int n = 1; n <= 60; n++) begin
            @(posedge pclk);
            if (low_irq === 1'b1 && t_lo == 0) t_lo = n;
            if (high_irq === 1'b1 && t_hi == 0) t_hi = n;
        end
        chk(t_lo >= 20 && t_lo <= 23, $sformatf("low period %0d", t_lo));
        chk(t_hi >= 8 && t_hi <= 11, $sformatf("high period %0d", t_hi));
        // Mode 2: sixteen-bit prescaled timer, period of 257 prescaler pulses
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_PRESCALE, 8'h00);
        wr(OFF_MATCH_LO, 8'h00);
        wr(OFF_MATCH_HI, 8'h01);
        wr(OFF_CONTROL, 8'he5);
        t_lo = 0;
        t_hi = 0;
        for (int n = 1; n <= 300; n++) begin
            @(posedge pclk);
            if (low_irq === 1'b1 && t_lo == 0) t_lo = n;
            if (high_irq === 1'b1 && t_hi == 0) t_hi = n;
        end
        chk(t_lo == t_hi && t_lo >= 250 && t_lo <= 260, $sformatf("long period %0d", t_lo));
        cyc(4);
        results();
    end
endmodule
`default_nettype wire
